// ### scs_config_slave.sv
// two-wire configuration slave with reset straps and init hold-off
// Function
// - enable only if both pins high first millisecond
// - legacy reaches 2.0 set, advanced both sets
// - legacy needs extra pull-up on strap pin
// - mode strap sampled at end of strap window, then fixed
// - enabled: hold init until host says done
// - any pin low: stay disabled, init at once
// - serial writes override one-time-programmable values
// - only block write and block read accepted; only block write changes registers
// - answer only the strapped 7-bit address
// - abort and release after 25 ms clock low
// - reset communication well before 35 ms
// - tolerate stretching, stretch clock when busy
// - start followed by stop returns to idle
// - no alert output, no alert response address
// - hardware reset distinct from bus reset
// - reset ends every transfer at once
// - reset returns every register to default
`timescale 1ns/1ps
`default_nettype none

module scs_config_slave #(
	parameter int unsigned STRAP_WINDOW   = scs_pkg::STRAP_CYCLES,
	parameter int unsigned TIMEOUT_LIMIT  = scs_pkg::TIMEOUT_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       cfg_serial_clock_pin_in,
	output var  logic       cfg_serial_clock_pin_out,
	output var  logic       cfg_serial_clock_pin_oe_n,
	input  wire logic       cfg_serial_data_pin_in,
	output var  logic       cfg_serial_data_pin_out,
	output var  logic       cfg_serial_data_pin_oe_n,
	input  wire logic       legacy_strap_pin,
	input  wire logic       addr_select_pin,
	input  wire logic       otp_wr_en,
	input  wire logic [5:0] otp_wr_index,
	input  wire logic [7:0] otp_wr_data,
	input  wire logic [5:0] reg_rd_index,
	output var  logic [7:0] reg_rd_data,
	output var  logic       slave_enabled,
	output var  logic       legacy_mode,
	output var  logic       init_release
);

	// index check shared by commit and read-back paths
	function automatic logic idx_ok(input logic [7:0] idx, input logic legacy);
		idx_ok = legacy ? (idx < scs_pkg::LEGACY_LIMIT) : (idx < scs_pkg::ADVANCED_LIMIT);
	endfunction

	logic [1:0]             scl_sync;
	logic [1:0]             sda_sync;
	logic [1:0]             strap_sync;
	logic [1:0]             asel_sync;
	logic                   scl_d;
	logic                   sda_d;
	logic                   scl_s;
	logic                   sda_s;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_det;
	logic                   stop_det;

	logic [scs_pkg::CNT_W-1:0] strap_cnt;
	logic                   strap_done;
	logic                   both_high;
	logic                   addr_sel;

	logic [scs_pkg::CNT_W-1:0] low_cnt;
	logic                   timeout;

	scs_pkg::scs_state_t    state;
	scs_pkg::scs_phase_t    phase;
	logic [2:0]             bit_cnt;
	logic                   byte_done;
	logic [7:0]             shreg;
	logic [7:0]             tx_sh;
	logic [7:0]             cmd_reg;
	logic                   got_cmd;
	logic [5:0]             count;
	logic [5:0]             data_idx;
	logic [4:0]             commit_i;
	logic                   commit_pend;
	logic                   master_ack;
	logic [7:0]             rd_ptr;

	logic [7:0]             mem [0:scs_pkg::REG_COUNT-1];
	logic                   written [0:scs_pkg::REG_COUNT-1];
	logic [7:0]             blk_buf [0:scs_pkg::BLOCK_MAX-1];

	logic [6:0]             my_addr;
	logic                   rx_byte_end;
	logic                   buf_we;
	logic [7:0]             commit_index;
	logic                   commit_we;
	logic [7:0]             rd_index;
	logic [7:0]             rd_byte;

	// pins pass two flops; the second stage feeds logic, with one more delay flop on the bus lines for edges
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync   <= {2{scs_pkg::SYNC_RESET}};
			sda_sync   <= {2{scs_pkg::SYNC_RESET}};
			strap_sync <= 2'h0;
			asel_sync  <= 2'h0;
			scl_d      <= scs_pkg::SYNC_RESET;
			sda_d      <= scs_pkg::SYNC_RESET;
		end else begin
			scl_sync   <= {scl_sync[0], cfg_serial_clock_pin_in};
			sda_sync   <= {sda_sync[0], cfg_serial_data_pin_in};
			strap_sync <= {strap_sync[0], legacy_strap_pin};
			asel_sync  <= {asel_sync[0], addr_select_pin};
			scl_d      <= scl_sync[1];
			sda_d      <= sda_sync[1];
		end
	end

	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	// strap window: bus pins watched for the whole first millisecond, strap pins sampled at its end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			strap_cnt     <= '0;
			strap_done    <= 1'b0;
			both_high     <= 1'b1;
			slave_enabled <= 1'b0;
			legacy_mode   <= 1'b0;
			addr_sel      <= 1'b0;
		end else if (!strap_done) begin
			both_high <= both_high & scl_s & sda_s;
			if (strap_cnt == scs_pkg::CNT_W'(STRAP_WINDOW - 1)) begin
				strap_done    <= 1'b1;
				slave_enabled <= both_high & scl_s & sda_s;
				legacy_mode   <= both_high & scl_s & sda_s & strap_sync[1];
				addr_sel      <= asel_sync[1];
			end else begin
				strap_cnt <= strap_cnt + 1'b1;
			end
		end
	end

	// init held through the strap window, then only while the slave is enabled and not yet told done
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			init_release <= 1'b0;
		end else if (strap_done && !slave_enabled) begin
			init_release <= 1'b1;
		end else if (commit_we == 1'b0 && state == scs_pkg::SCS_COMMIT
				&& cmd_reg == scs_pkg::CMD_CONFIG_DONE) begin
			init_release <= 1'b1;
		end
	end

	// clock-low watchdog; our own stretch is short and never trips it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= '0;
			timeout <= 1'b0;
		end else if (scl_s) begin
			low_cnt <= '0;
			timeout <= 1'b0;
		end else if (low_cnt == scs_pkg::CNT_W'(TIMEOUT_LIMIT - 1)) begin
			low_cnt <= '0;
			timeout <= 1'b1;
		end else begin
			low_cnt <= low_cnt + 1'b1;
			timeout <= 1'b0;
		end
	end

	assign my_addr      = addr_sel ? scs_pkg::ADDR_HIGH : scs_pkg::ADDR_LOW;
	assign rx_byte_end  = (state == scs_pkg::SCS_RX) && scl_fall && byte_done;
	assign buf_we       = rx_byte_end && phase == scs_pkg::SCS_PH_DATA && data_idx < count;
	assign commit_index = cmd_reg + {3'h0, commit_i};
	assign commit_we    = (state == scs_pkg::SCS_COMMIT) && idx_ok(commit_index, legacy_mode);
	assign rd_index     = cmd_reg + rd_ptr;
	assign rd_byte      = idx_ok(rd_index, legacy_mode) ? mem[rd_index[5:0]] : 8'h00;

	// protocol engine
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state       <= scs_pkg::SCS_IDLE;
			phase       <= scs_pkg::SCS_PH_ADDR;
			bit_cnt     <= 3'h0;
			byte_done   <= 1'b0;
			shreg       <= 8'h00;
			tx_sh       <= 8'h00;
			cmd_reg     <= 8'h00;
			got_cmd     <= 1'b0;
			count       <= 6'h00;
			data_idx    <= 6'h00;
			commit_i    <= 5'h00;
			commit_pend <= 1'b0;
			master_ack  <= 1'b0;
			rd_ptr      <= 8'h00;
			cfg_serial_data_pin_oe_n  <= scs_pkg::OE_N_RESET;
			cfg_serial_clock_pin_oe_n <= scs_pkg::OE_N_RESET;
		end else if (!slave_enabled || timeout || stop_det) begin
			state       <= scs_pkg::SCS_IDLE;
			got_cmd     <= 1'b0;
			commit_pend <= 1'b0;
			cfg_serial_data_pin_oe_n  <= 1'b1;
			cfg_serial_clock_pin_oe_n <= 1'b1;
		end else if (start_det && state != scs_pkg::SCS_COMMIT) begin
			state     <= scs_pkg::SCS_RX;
			phase     <= scs_pkg::SCS_PH_ADDR;
			bit_cnt   <= 3'h0;
			byte_done <= 1'b0;
			cfg_serial_data_pin_oe_n <= 1'b1;
		end else begin
			unique case (state)
				scs_pkg::SCS_IDLE: begin
				end
				scs_pkg::SCS_RX: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == 3'h7) begin
							byte_done <= 1'b1;
						end
					end else if (rx_byte_end) begin
						byte_done <= 1'b0;
						state     <= scs_pkg::SCS_IDLE;
						unique case (phase)
							scs_pkg::SCS_PH_ADDR: begin
								if (shreg[7:1] == my_addr && !shreg[0]) begin
									phase <= scs_pkg::SCS_PH_CMD;
									state <= scs_pkg::SCS_RX_ACK;
									cfg_serial_data_pin_oe_n <= 1'b0;
								end else if (shreg[7:1] == my_addr && got_cmd) begin
									phase  <= scs_pkg::SCS_PH_READ;
									rd_ptr <= 8'h00;
									state  <= scs_pkg::SCS_RX_ACK;
									cfg_serial_data_pin_oe_n <= 1'b0;
								end
							end
							scs_pkg::SCS_PH_CMD: begin
								cmd_reg <= shreg;
								got_cmd <= 1'b1;
								phase   <= scs_pkg::SCS_PH_COUNT;
								state   <= scs_pkg::SCS_RX_ACK;
								cfg_serial_data_pin_oe_n <= 1'b0;
							end
							scs_pkg::SCS_PH_COUNT: begin
								if (shreg != 8'h00 && shreg <= {2'h0, scs_pkg::BLOCK_MAX_COUNT}) begin
									count    <= shreg[5:0];
									data_idx <= 6'h00;
									phase    <= scs_pkg::SCS_PH_DATA;
									state    <= scs_pkg::SCS_RX_ACK;
									cfg_serial_data_pin_oe_n <= 1'b0;
								end
							end
							scs_pkg::SCS_PH_DATA: begin
								if (buf_we) begin
									data_idx <= data_idx + 1'b1;
									commit_pend <= (data_idx + 1'b1 == count);
									state <= scs_pkg::SCS_RX_ACK;
									cfg_serial_data_pin_oe_n <= 1'b0;
								end
							end
							default: begin
							end
						endcase
					end
				end
				scs_pkg::SCS_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (phase == scs_pkg::SCS_PH_READ) begin
							tx_sh <= scs_pkg::READ_COUNT;
							state <= scs_pkg::SCS_TX;
							cfg_serial_data_pin_oe_n <= scs_pkg::READ_COUNT[7];
						end else if (commit_pend) begin
							commit_i <= 5'h00;
							state    <= scs_pkg::SCS_COMMIT;
							cfg_serial_data_pin_oe_n  <= 1'b1;
							cfg_serial_clock_pin_oe_n <= 1'b0;
						end else begin
							state <= scs_pkg::SCS_RX;
							cfg_serial_data_pin_oe_n <= 1'b1;
						end
					end
				end
				scs_pkg::SCS_COMMIT: begin
					commit_i <= commit_i + 1'b1;
					if ({1'b0, commit_i} == count - 1'b1) begin
						commit_pend <= 1'b0;
						state       <= scs_pkg::SCS_RX;
						cfg_serial_clock_pin_oe_n <= 1'b1;
					end
				end
				scs_pkg::SCS_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							bit_cnt <= 3'h0;
							state   <= scs_pkg::SCS_TX_ACK;
							cfg_serial_data_pin_oe_n <= 1'b1;
						end else begin
							bit_cnt <= bit_cnt + 1'b1;
							tx_sh   <= {tx_sh[6:0], 1'b0};
							cfg_serial_data_pin_oe_n <= tx_sh[6];
						end
					end
				end
				scs_pkg::SCS_TX_ACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_s;
					end else if (scl_fall) begin
						if (master_ack) begin
							tx_sh  <= rd_byte;
							rd_ptr <= rd_ptr + 1'b1;
							state  <= scs_pkg::SCS_TX;
							cfg_serial_data_pin_oe_n <= rd_byte[7];
						end else begin
							state <= scs_pkg::SCS_IDLE;
						end
					end
				end
				default: begin
					state <= scs_pkg::SCS_IDLE;
				end
			endcase
		end
	end

	// staging buffer: nothing lands in registers until the block is complete
	always_ff @(posedge clock) begin
		if (buf_we) begin
			blk_buf[data_idx[4:0]] <= shreg;
		end
	end

	// register file; serial writes mark an entry so later otp loads skip it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < scs_pkg::REG_COUNT; i++) begin
				mem[i]     <= scs_pkg::REG_RESET;
				written[i] <= 1'b0;
			end
		end else if (commit_we) begin
			mem[commit_index[5:0]]     <= blk_buf[commit_i];
			written[commit_index[5:0]] <= 1'b1;
		end else if (otp_wr_en && !written[otp_wr_index]) begin
			mem[otp_wr_index] <= otp_wr_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_data              <= scs_pkg::REG_RESET;
			cfg_serial_data_pin_out  <= scs_pkg::PIN_OUT_RESET;
			cfg_serial_clock_pin_out <= scs_pkg::PIN_OUT_RESET;
		end else begin
			reg_rd_data              <= mem[reg_rd_index];
			cfg_serial_data_pin_out  <= scs_pkg::PIN_OUT_RESET;
			cfg_serial_clock_pin_out <= scs_pkg::PIN_OUT_RESET;
		end
	end

endmodule // scs_config_slave

`default_nettype wire

// ### scs_config_slave_checker.sv
// port assertions for the configuration serial slave
`timescale 1ns/1ps
`default_nettype none

module scs_config_slave_checker #(
	parameter int unsigned TIMEOUT_LIMIT = scs_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic cfg_serial_clock_pin_in,
	input wire logic cfg_serial_clock_pin_out,
	input wire logic cfg_serial_clock_pin_oe_n,
	input wire logic cfg_serial_data_pin_out,
	input wire logic cfg_serial_data_pin_oe_n,
	input wire logic slave_enabled,
	input wire logic legacy_mode,
	input wire logic init_release
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	logic [31:0] low_cnt;
	logic [7:0]  st_cnt;
	wire logic   free;
	assign free = cfg_serial_clock_pin_oe_n && cfg_serial_data_pin_oe_n;

	// restarts on every high level, so stretches by anyone count as low
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= '0;
		end else if (cfg_serial_clock_pin_in) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= low_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_cnt <= '0;
		end else if (cfg_serial_clock_pin_oe_n) begin
			st_cnt <= '0;
		end else begin
			st_cnt <= st_cnt + 8'h01;
		end
	end

	a_outs_zero: assert property (!cfg_serial_clock_pin_out && !cfg_serial_data_pin_out)
		else $error("pin output level not zero");
	a_off_quiet: assert property (!slave_enabled |-> free)
		else $error("disabled slave drives a line");
	a_enable_sticky: assert property ($past(slave_enabled) |-> slave_enabled)
		else $error("enable dropped without reset");
	a_mode_needs_en: assert property (legacy_mode |-> slave_enabled)
		else $error("legacy mode while disabled");
	a_mode_fixed: assert property ($past(slave_enabled, 2) |-> $stable(legacy_mode))
		else $error("mode changed after sampling");
	a_hold_at_enable: assert property ($rose(slave_enabled) |-> !init_release)
		else $error("init released at enable");
	a_release_sticky: assert property ($past(init_release) |-> init_release)
		else $error("init release withdrawn");
	a_timeout_free: assert property (low_cnt > TIMEOUT_LIMIT + 8 |-> free)
		else $error("lines held after clock-low timeout");
	a_stretch_short: assert property (st_cnt <= 8'h28)
		else $error("clock stretch too long");
	a_reset_quiet: assert property ($rose(reset_n) |-> free && !slave_enabled && !init_release)
		else $error("state kept across reset");

	cover property ($rose(slave_enabled));
	cover property ($rose(init_release) && slave_enabled);
	cover property ($fell(cfg_serial_clock_pin_oe_n));
	cover property (low_cnt > TIMEOUT_LIMIT + 8);
endmodule // scs_config_slave_checker

bind scs_config_slave scs_config_slave_checker #(
	.TIMEOUT_LIMIT(TIMEOUT_LIMIT)
) u_scs_config_slave_checker (
	.clock, .reset_n, .cfg_serial_clock_pin_in, .cfg_serial_clock_pin_out,
	.cfg_serial_clock_pin_oe_n, .cfg_serial_data_pin_out, .cfg_serial_data_pin_oe_n,
	.slave_enabled, .legacy_mode, .init_release
);

`default_nettype wire

// ### scs_host_model.sv
// behavioural two-wire host that configures the slave
`timescale 1ns/1ps
`default_nettype none

module scs_host_model (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_oe_n,
	output var  logic sda_oe_n,
	output var  logic stuck
);
	// quarter of a 125 ns bus period
	localparam realtime Q = 31.25;

	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		stuck = 1'b0;
	end

	// follow the wire, not the timer, so stretching is honoured
	task automatic rise();
		int n;
		scl_oe_n = 1'b1;
		for (n = 0; n < 800 && scl !== 1'b1; n++) #1;
		if (n == 800) stuck = 1'b1;
		#Q;
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_oe_n = b;
		#Q;
		rise();
		r = sda;
		#Q;
		scl_oe_n = 1'b0;
		#Q;
	endtask

	task automatic start();
		sda_oe_n = 1'b1;
		#Q;
		rise();
		sda_oe_n = 1'b0;
		#Q;
		scl_oe_n = 1'b0;
		#Q;
	endtask

	task automatic stop();
		sda_oe_n = 1'b0;
		#Q;
		rise();
		sda_oe_n = 1'b1;
		#Q;
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic rbyte(output logic [7:0] b, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(last, r);
	endtask

	task automatic hold_low(input realtime t);
		scl_oe_n = 1'b0;
		#t;
	endtask

	task automatic free();
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	endtask
endmodule // scs_host_model

`default_nettype wire

// ### scs_pkg.sv
// constants and types shared by the configuration serial slave
package scs_pkg;

	// device clock rate and the times derived from it
	localparam int unsigned CLK_MHZ          = 250;
	localparam int unsigned STRAP_WINDOW_US  = 1000;
	localparam int unsigned STRAP_CYCLES     = STRAP_WINDOW_US * CLK_MHZ;
	localparam int unsigned TIMEOUT_MS       = 25;
	localparam int unsigned TIMEOUT_CYCLES   = TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int unsigned RELEASE_MAX_MS   = 35;
	localparam int unsigned CNT_W            = 23;

	// slave addresses, picked by the address select pin
	localparam logic [6:0] ADDR_LOW          = 7'h2C;
	localparam logic [6:0] ADDR_HIGH         = 7'h2D;

	// register space: low half is the 2.0 set, upper half the 3.0 set
	localparam int unsigned REG_COUNT        = 64;
	localparam logic [7:0] LEGACY_LIMIT      = 8'h20;
	localparam logic [7:0] ADVANCED_LIMIT    = 8'h40;
	localparam logic [7:0] REG_RESET         = 8'h00;

	// block transfer limits and special commands
	localparam int unsigned BLOCK_MAX        = 32;
	localparam logic [5:0] BLOCK_MAX_COUNT   = 6'h20;
	localparam logic [7:0] READ_COUNT        = 8'h20;
	localparam logic [7:0] CMD_CONFIG_DONE   = 8'hFF;

	// reset values of pin drivers and status
	localparam logic       OE_N_RESET        = 1'b1;
	localparam logic       PIN_OUT_RESET     = 1'b0;
	localparam logic       SYNC_RESET        = 1'b1;

	typedef enum logic [2:0] {
		SCS_IDLE    = 3'b000,
		SCS_RX      = 3'b001,
		SCS_RX_ACK  = 3'b011,
		SCS_COMMIT  = 3'b111,
		SCS_TX      = 3'b010,
		SCS_TX_ACK  = 3'b110
	} scs_state_t;

	typedef enum logic [2:0] {
		SCS_PH_ADDR  = 3'b000,
		SCS_PH_CMD   = 3'b001,
		SCS_PH_COUNT = 3'b011,
		SCS_PH_DATA  = 3'b010,
		SCS_PH_READ  = 3'b110
	} scs_phase_t;

endpackage

// ### tb_scs_config_slave.sv
// self-checking bench for the configuration serial slave
`timescale 1ns/1ps
`default_nettype none

module tb_scs_config_slave;
	localparam int unsigned SW = 20;
	localparam int unsigned TL = 200;
	// a valid hardware reset lasts 1 us, 250 clocks of 4 ns
	localparam int          RST_HOLD = 250;
	localparam logic [6:0]  AL = scs_pkg::ADDR_LOW;
	localparam logic [6:0]  AH = scs_pkg::ADDR_HIGH;

	logic       clock = 1'b0;
	logic       reset_n = 1'b0;
	logic       pd = 1'b0;
	logic       strap = 1'b0;
	logic       asel = 1'b0;
	logic       otp_en = 1'b0;
	logic [5:0] otp_idx = 6'h00;
	logic [7:0] otp_dat = 8'h00;
	logic [5:0] rd_idx = 6'h00;
	logic [7:0] rd_dat;
	logic       en;
	logic       lg;
	logic       init;
	logic       c_out;
	logic       c_oe_n;
	logic       d_out;
	logic       d_oe_n;
	logic       h_scl;
	logic       h_sda;
	logic       stuck;
	logic       ack;
	logic [7:0] rb;
	int         n_fail = 0;
	int         n_tests = 0;
	// pulled-up wires: anyone enabling pulls low
	wire logic  scl = h_scl & (c_oe_n | c_out) & !pd;
	wire logic  sda = h_sda & (d_oe_n | d_out) & !pd;

	always #2 clock = ~clock;

	scs_config_slave #(.STRAP_WINDOW(SW), .TIMEOUT_LIMIT(TL)) u_scs_config_slave (
		.clock(clock), .reset_n(reset_n),
		.cfg_serial_clock_pin_in(scl), .cfg_serial_clock_pin_out(c_out),
		.cfg_serial_clock_pin_oe_n(c_oe_n), .cfg_serial_data_pin_in(sda),
		.cfg_serial_data_pin_out(d_out), .cfg_serial_data_pin_oe_n(d_oe_n),
		.legacy_strap_pin(strap), .addr_select_pin(asel), .otp_wr_en(otp_en),
		.otp_wr_index(otp_idx), .otp_wr_data(otp_dat), .reg_rd_index(rd_idx),
		.reg_rd_data(rd_dat), .slave_enabled(en), .legacy_mode(lg), .init_release(init)
	);

	scs_host_model u_scs_host_model (
		.scl(scl), .sda(sda), .scl_oe_n(h_scl), .sda_oe_n(h_sda), .stuck(stuck)
	);

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic p, input logic l, input logic a, input int hold);
		@(posedge clock);
		reset_n <= 1'b0;
		pd <= p;
		strap <= l;
		asel <= a;
		repeat (hold) @(posedge clock);
		reset_n <= 1'b1;
		repeat (SW + 6) @(posedge clock);
	endtask

	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		@(posedge clock);
		rd_idx <= i;
		@(posedge clock);
		@(negedge clock);
		chk("reg_rd_data", e, rd_dat);
	endtask

	task automatic otp(input logic [5:0] i, input logic [7:0] d);
		@(posedge clock);
		otp_en <= 1'b1;
		otp_idx <= i;
		otp_dat <= d;
		@(posedge clock);
		otp_en <= 1'b0;
	endtask

	task automatic bwrite(input logic [6:0] a, input logic [7:0] c, input int n,
			input logic [7:0] b);
		logic k;
		u_scs_host_model.start();
		u_scs_host_model.wbyte({a, 1'b0}, ack);
		u_scs_host_model.wbyte(c, k);
		u_scs_host_model.wbyte(8'(n), k);
		for (int i = 0; i < n; i++) u_scs_host_model.wbyte(b + 8'(i), k);
		u_scs_host_model.stop();
	endtask

	task automatic t_straps();
		do_reset(1'b1, 1'b1, 1'b0, 3);
		chk("slave_enabled", 8'h00, en);
		chk("legacy_mode", 8'h00, lg);
		chk("init_release", 8'h01, init);
		do_reset(1'b0, 1'b0, 1'b0, RST_HOLD);
		chk("slave_enabled", 8'h01, en);
		chk("legacy_mode", 8'h00, lg);
		chk("init_release", 8'h00, init);
	endtask

	task automatic t_write();
		otp(6'h03, 8'hA5);
		rd(6'h03, 8'hA5);
		bwrite(AL, 8'h03, 2, 8'h10);
		chk("address ack", 8'h01, ack);
		rd(6'h03, 8'h10);
		rd(6'h04, 8'h11);
		otp(6'h03, 8'h77);
		rd(6'h03, 8'h10);
		bwrite(AL, 8'h28, 1, 8'h60);
		rd(6'h28, 8'h60);
	endtask

	task automatic t_refuse();
		bwrite(AH, 8'h03, 1, 8'hEE);
		chk("address ack", 8'h00, ack);
		bwrite(7'h0C, 8'h03, 1, 8'hEE);
		chk("address ack", 8'h00, ack);
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b0}, ack);
		u_scs_host_model.wbyte(8'h03, ack);
		u_scs_host_model.wbyte(8'h01, ack);
		u_scs_host_model.stop();
		rd(6'h03, 8'h10);
	endtask

	task automatic t_read();
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b0}, ack);
		u_scs_host_model.wbyte(8'h03, ack);
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b1}, ack);
		chk("read address ack", 8'h01, ack);
		u_scs_host_model.rbyte(rb, 1'b0);
		chk("read count", scs_pkg::READ_COUNT, rb);
		u_scs_host_model.rbyte(rb, 1'b0);
		chk("read byte", 8'h10, rb);
		u_scs_host_model.rbyte(rb, 1'b1);
		chk("read byte", 8'h11, rb);
		u_scs_host_model.stop();
	endtask

	task automatic t_recover();
		u_scs_host_model.start();
		u_scs_host_model.stop();
		bwrite(AL, 8'h05, 1, 8'h42);
		rd(6'h05, 8'h42);
		// time out while the slave drives the count byte's low first bit
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b0}, ack);
		u_scs_host_model.wbyte(8'h05, ack);
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b1}, ack);
		chk("read address ack", 8'h01, ack);
		chk("data oe_n before timeout", 8'h00, d_oe_n);
		u_scs_host_model.hold_low(TL * 8);
		chk("clock oe_n", 8'h01, c_oe_n);
		chk("data oe_n", 8'h01, d_oe_n);
		u_scs_host_model.stop();
		bwrite(AL, 8'h05, 1, 8'h33);
		rd(6'h05, 8'h33);
	endtask

	task automatic t_done();
		chk("init_release", 8'h00, init);
		bwrite(AL, scs_pkg::CMD_CONFIG_DONE, 1, 8'h00);
		for (int i = 0; i < 50 && init !== 1'b1; i++) @(posedge clock);
		chk("init_release", 8'h01, init);
	endtask

	task automatic t_reset_mid();
		u_scs_host_model.start();
		u_scs_host_model.wbyte({AL, 1'b0}, ack);
		u_scs_host_model.wbyte(8'h06, ack);
		u_scs_host_model.free();
		do_reset(1'b0, 1'b1, 1'b1, RST_HOLD);
		rd(6'h03, 8'h00);
		chk("init_release", 8'h00, init);
		chk("legacy_mode", 8'h01, lg);
		@(posedge clock);
		strap <= 1'b0;
		repeat (4) @(posedge clock);
		chk("legacy_mode", 8'h01, lg);
		bwrite(AH, 8'h28, 1, 8'h55);
		chk("address ack", 8'h01, ack);
		rd(6'h28, 8'h00);
		bwrite(AH, 8'h02, 1, 8'h66);
		rd(6'h02, 8'h66);
	endtask

	initial begin
		t_straps();
		t_write();
		t_refuse();
		t_read();
		t_recover();
		t_done();
		t_reset_mid();
		chk("host stuck", 8'h00, stuck);
		test_done();
	end
endmodule // tb_scs_config_slave

`default_nettype wire
